// File: rtl/pin_mux_pkg.sv
// Notes on behaviour
// R1: five-signal scan test port; clock, data in, mode select, data out share GPIO pins.
// R2: test reset input decides whether shared test pins serve the scan port or GPIO.
// R3: while the test port is selected, GPIO function of shared pins is unavailable.
// R4: each pin has 2-bit function selector; 00 is GPIO and reset value; 01-11 peripherals.
// R5: up to three peripheral signals per pin, plus direct software drive and read.
// R6: software must not program reserved selector values; pin state is then undefined.
// R7: pin n selector sits at bits 2n+1:2n; low register pins 0-15, high 16-31.
// R8: qualify code 00 is reset default and only synchronizes the input.
// R9: codes 01 and 10 synchronize, then qualify over a sampling window.
// R10: window holds three or six samples, chosen by the qualify code.
// R11: qualified output changes only when all window samples agree.
// R12: sample interval is a multiple of clock cycles, set per group of 8 pins.
// R13: qualify code 11 passes the pin input without synchronization.
// R14: unselected peripheral input sees its fixed default level.
// R15: one peripheral input may be selectable on more than one pin.
// R16: data register: write updates output latch, read returns pin input value.
// R17: period zero samples every cycle; value n samples every 2n cycles, up to 0xFF.
// R18: selector and qualify-select writes take effect two clock cycles later.
// R19: with selector 00 output enable follows direction bit, value from data latch.
package pin_mux_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_QUAL_CTRL = 8'h00;
	localparam logic [7:0] OFS_QSEL_LOW = 8'h04;
	localparam logic [7:0] OFS_QSEL_HIGH = 8'h08;
	localparam logic [7:0] OFS_FSEL_LOW = 8'h0C;
	localparam logic [7:0] OFS_FSEL_HIGH = 8'h10;
	localparam logic [7:0] OFS_DIRECTION = 8'h14;
	localparam logic [7:0] OFS_PIN_DATA = 8'h18;
	localparam logic [31:0] RST_REG = 32'h00000000;
	localparam int PERIOD_W = 8;
	localparam int GROUP_PINS = 8;
	localparam int SEL_W = 2;
	localparam int CFG_DELAY = 2;
	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] FSEL_GPIO = 2'h0;
	localparam logic [1:0] QSEL_SYNC = 2'h0;
	localparam logic [1:0] QSEL_WIN3 = 2'h1;
	localparam logic [1:0] QSEL_WIN6 = 2'h2;
	localparam logic [1:0] QSEL_ASYNC = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int WIN_MAX = 6;
	localparam int CNT_W = PERIOD_W + 1;
endpackage : pin_mux_pkg

// File: rtl/qual_if.sv
`timescale 1ns/100ps
interface qual_if;
	import pin_mux_pkg::*;
	logic [PERIOD_W-1:0] period;
	logic [2*GROUP_PINS-1:0] qsel;
	logic [GROUP_PINS-1:0] raw;
	logic [GROUP_PINS-1:0] qual;
	modport top (output period, output qsel, output raw, input qual);
	modport grp (input period, input qsel, input raw, output qual);
endinterface : qual_if

// File: rtl/input_qualifier.sv
`timescale 1ns/100ps
module input_qualifier (
	input wire logic clk,
	input wire logic rstSync_n,
	qual_if.grp q
);
	import pin_mux_pkg::*;

	function automatic logic allSame(input logic [WIN_MAX-1:0] w, input logic six);
		allSame = six ? (&w || ~|w) : (&w[2:0] || ~|w[2:0]);
	endfunction : allSame

	logic [GROUP_PINS-1:0] syncA_ff;
	logic [GROUP_PINS-1:0] syncB_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [GROUP_PINS-1:0][WIN_MAX-1:0] win_ff;
	logic [GROUP_PINS-1:0] held_ff;
	wire logic [CNT_W-1:0] lastCnt = CNT_W'({q.period, 1'b0} - 1'b1);
	wire logic tick = (q.period == '0) || (cnt_ff == lastCnt); // R12 R17
	wire logic [CNT_W-1:0] nxt_cnt = tick ? '0 : CNT_W'(cnt_ff + 1'b1);

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			syncA_ff <= '0;
			syncB_ff <= '0;
			cnt_ff <= '0;
		end else begin
			syncA_ff <= q.raw;
			syncB_ff <= syncA_ff;
			cnt_ff <= nxt_cnt;
		end
	end

	genvar i;
	generate
		for (i = 0; i < GROUP_PINS; i++) begin : g_pin
			wire logic [1:0] code = q.qsel[2*i +: 2];
			wire logic [WIN_MAX-1:0] nxt_win = {win_ff[i][WIN_MAX-2:0], syncB_ff[i]};
			wire logic agree = allSame(nxt_win, code == QSEL_WIN6); // R10 R11
			always_ff @(posedge clk or negedge rstSync_n) begin
				if (!rstSync_n) begin
					win_ff[i] <= '0;
					held_ff[i] <= 1'b0;
				end else if (tick) begin
					win_ff[i] <= nxt_win; // R9
					if (agree) begin
						held_ff[i] <= syncB_ff[i]; // R11
					end
				end
			end
			// sync only, windowed, or raw pass-through
			assign q.qual[i] = (code == QSEL_SYNC) ? syncB_ff[i] : // R8
				(code == QSEL_ASYNC) ? q.raw[i] : held_ff[i]; // R13 R9
		end
	endgenerate
endmodule : input_qualifier

// File: rtl/pin_function_mux_qualifier.sv
`timescale 1ns/100ps
module pin_function_mux_qualifier #(
	parameter int PINS = 32,
	parameter int N_PERIN = 16,
	parameter logic [N_PERIN-1:0] PERIN_DEFAULT = '0,
	parameter int TCK_PIN = 28,
	parameter int TDI_PIN = 29,
	parameter int TMS_PIN = 30,
	parameter int TDO_PIN = 31
) (
	input wire logic clk,
	input wire logic rst_n,
	// AXI4-Lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// pins
	input wire logic [PINS-1:0] pinIn,
	output logic [PINS-1:0] pinOut,
	output logic [PINS-1:0] pinOe,
	// peripherals: entry 3*pin+sel-1 is that pin's choice sel
	input wire logic [3*PINS-1:0] periphOut,
	input wire logic [3*PINS-1:0] periphOe,
	output logic [N_PERIN-1:0] periphIn,
	// scan test port
	input wire logic testReset,
	input wire logic scanDataOut,
	input wire logic scanDataOutOe,
	output logic scanClock,
	output logic scanDataIn,
	output logic scanModeSel
);
	import pin_mux_pkg::*;

	localparam int GROUPS = PINS / GROUP_PINS;

	if (PINS % GROUP_PINS != 0 || PINS > 32 || PINS < GROUP_PINS || N_PERIN < 1 ||
		TCK_PIN >= PINS || TDI_PIN >= PINS || TMS_PIN >= PINS || TDO_PIN >= PINS) begin : g_bad
		$error("pin_function_mux_qualifier: unsupported parameters");
	end

	// peripheral input reached by choice sel of pin p; several pins share one input
	function automatic int perinIndex(input int p, input int sel);
		perinIndex = (3 * p + sel - 1) % N_PERIN; // R15
	endfunction : perinIndex

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		merge = r;
	endfunction : merge

	function automatic logic isScanPin(input int p);
		isScanPin = (p == TCK_PIN) || (p == TDI_PIN) || (p == TMS_PIN) || (p == TDO_PIN); // R1
	endfunction : isScanPin

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rstMeta_ff;
	logic rstSync_n;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_ff <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstSync_n <= rstMeta_ff;
		end
	end

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	logic awHeld_ff, wHeld_ff;
	logic [7:0] awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic [31:0] qualCtrl_ff, qselLow_ff, qselHigh_ff, fselLow_ff, fselHigh_ff, dir_ff, dataLatch_ff;
	logic [PINS-1:0] pinQual;

	wire logic awTake = awvalid && awready_ff;
	wire logic wTake = wvalid && wready_ff;
	wire logic doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
	wire logic nxt_awHeld = (awHeld_ff && !doWrite) || awTake;
	wire logic nxt_wHeld = (wHeld_ff && !doWrite) || wTake;
	wire logic nxt_bvalid = doWrite || (bvalid_ff && !bready);
	wire logic arTake = arvalid && arready_ff;
	wire logic nxt_rvalid = arTake || (rvalid_ff && !rready);

	wire logic wrCtrl = doWrite && awAddr_ff == OFS_QUAL_CTRL;
	wire logic wrQselLo = doWrite && awAddr_ff == OFS_QSEL_LOW;
	wire logic wrQselHi = doWrite && awAddr_ff == OFS_QSEL_HIGH;
	wire logic wrFselLo = doWrite && awAddr_ff == OFS_FSEL_LOW;
	wire logic wrFselHi = doWrite && awAddr_ff == OFS_FSEL_HIGH;
	wire logic wrDir = doWrite && awAddr_ff == OFS_DIRECTION;
	wire logic wrData = doWrite && awAddr_ff == OFS_PIN_DATA;
	wire logic wrHit = wrCtrl || wrQselLo || wrQselHi || wrFselLo || wrFselHi || wrDir || wrData;

	wire logic [31:0] pinRead = 32'(pinQual);
	wire logic rdHit = araddr inside {OFS_QUAL_CTRL, OFS_QSEL_LOW, OFS_QSEL_HIGH, OFS_FSEL_LOW,
		OFS_FSEL_HIGH, OFS_DIRECTION, OFS_PIN_DATA};
	wire logic [31:0] rdMux = (araddr == OFS_QUAL_CTRL) ? qualCtrl_ff :
		(araddr == OFS_QSEL_LOW) ? qselLow_ff :
		(araddr == OFS_QSEL_HIGH) ? qselHigh_ff :
		(araddr == OFS_FSEL_LOW) ? fselLow_ff :
		(araddr == OFS_FSEL_HIGH) ? fselHigh_ff :
		(araddr == OFS_DIRECTION) ? dir_ff :
		(araddr == OFS_PIN_DATA) ? pinRead : 32'h00000000; // R16

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
		end else begin
			awHeld_ff <= nxt_awHeld;
			wHeld_ff <= nxt_wHeld;
			awready_ff <= !nxt_awHeld;
			wready_ff <= !nxt_wHeld;
			bvalid_ff <= nxt_bvalid;
			arready_ff <= !nxt_rvalid;
			rvalid_ff <= nxt_rvalid;
		end
	end

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			awAddr_ff <= 8'h00;
			wData_ff <= 32'h00000000;
			wStrb_ff <= 4'h0;
			bresp_ff <= RESP_OKAY;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= 32'h00000000;
		end else begin
			if (awTake) awAddr_ff <= {awaddr[7:2], 2'b00};
			if (wTake) wData_ff <= wdata;
			if (wTake) wStrb_ff <= wstrb;
			if (doWrite) bresp_ff <= wrHit ? RESP_OKAY : RESP_SLVERR;
			if (arTake) rresp_ff <= rdHit ? RESP_OKAY : RESP_SLVERR;
			if (arTake) rdata_ff <= rdMux;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			qualCtrl_ff <= RST_REG;
			qselLow_ff <= RST_REG; // R8
			qselHigh_ff <= RST_REG;
			fselLow_ff <= RST_REG; // R4
			fselHigh_ff <= RST_REG;
			dir_ff <= RST_REG;
			dataLatch_ff <= RST_REG;
		end else begin
			if (wrCtrl) qualCtrl_ff <= merge(qualCtrl_ff, wData_ff, wStrb_ff); // R12
			if (wrQselLo) qselLow_ff <= merge(qselLow_ff, wData_ff, wStrb_ff);
			if (wrQselHi) qselHigh_ff <= merge(qselHigh_ff, wData_ff, wStrb_ff);
			if (wrFselLo) fselLow_ff <= merge(fselLow_ff, wData_ff, wStrb_ff); // R7
			if (wrFselHi) fselHigh_ff <= merge(fselHigh_ff, wData_ff, wStrb_ff); // R7
			if (wrDir) dir_ff <= merge(dir_ff, wData_ff, wStrb_ff);
			if (wrData) dataLatch_ff <= merge(dataLatch_ff, wData_ff, wStrb_ff); // R16
		end
	end

	// selector and qualify-select changes reach the logic after a fixed delay
	logic [CFG_DELAY-1:0][127:0] cfgPipe_ff;
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			cfgPipe_ff <= '0;
		end else begin
			cfgPipe_ff <= {cfgPipe_ff[CFG_DELAY-2:0], {fselHigh_ff, fselLow_ff, qselHigh_ff, qselLow_ff}}; // R18
		end
	end
	wire logic [63:0] qselEff = cfgPipe_ff[CFG_DELAY-1][63:0];
	wire logic [63:0] fselEff = cfgPipe_ff[CFG_DELAY-1][127:64];

	// ----------------------------------------------------------------
	// input qualification, one sample period per group
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < GROUPS; g++) begin : g_grp
			qual_if qIf ();
			assign qIf.period = qualCtrl_ff[PERIOD_W*g +: PERIOD_W]; // R12
			assign qIf.qsel = qselEff[2*GROUP_PINS*g +: 2*GROUP_PINS];
			assign qIf.raw = pinIn[GROUP_PINS*g +: GROUP_PINS];
			assign pinQual[GROUP_PINS*g +: GROUP_PINS] = qIf.qual;
			input_qualifier u_qual (
				.clk(clk),
				.rstSync_n(rstSync_n),
				.q(qIf.grp)
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// output routing and peripheral inputs
	// ----------------------------------------------------------------
	logic [PINS-1:0] nxt_pinOut, nxt_pinOe;
	logic [N_PERIN-1:0] nxt_periphIn;
	always_comb begin
		logic [1:0] sel;
		logic found;
		sel = FSEL_GPIO;
		found = 1'b0;
		for (int p = 0; p < PINS; p++) begin
			sel = fselEff[SEL_W*p +: SEL_W];
			if (testReset && isScanPin(p)) begin
				// R2 R3
				nxt_pinOut[p] = (p == TDO_PIN) && scanDataOut;
				nxt_pinOe[p] = (p == TDO_PIN) && scanDataOutOe;
			end else if (sel == FSEL_GPIO) begin
				nxt_pinOut[p] = dataLatch_ff[p]; // R19
				nxt_pinOe[p] = dir_ff[p]; // R19
			end else begin
				nxt_pinOut[p] = periphOut[3*p + int'(sel) - 1]; // R5
				nxt_pinOe[p] = periphOe[3*p + int'(sel) - 1]; // R5
			end
		end
		for (int k = 0; k < N_PERIN; k++) begin
			nxt_periphIn[k] = PERIN_DEFAULT[k]; // R14
			found = 1'b0;
			for (int p = 0; p < PINS; p++) begin
				sel = fselEff[SEL_W*p +: SEL_W];
				if (!found && sel != FSEL_GPIO && !(testReset && isScanPin(p)) &&
					perinIndex(p, int'(sel)) == k) begin
					nxt_periphIn[k] = pinQual[p]; // R15
					found = 1'b1;
				end
			end
		end
	end

	logic [PINS-1:0] pinOut_ff, pinOe_ff;
	logic [N_PERIN-1:0] periphIn_ff;
	logic scanClock_ff, scanDataIn_ff, scanModeSel_ff;
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			pinOut_ff <= '0;
			pinOe_ff <= '0;
			periphIn_ff <= PERIN_DEFAULT;
			scanClock_ff <= 1'b0;
			scanDataIn_ff <= 1'b0;
			scanModeSel_ff <= 1'b0;
		end else begin
			pinOut_ff <= nxt_pinOut;
			pinOe_ff <= nxt_pinOe;
			periphIn_ff <= nxt_periphIn;
			scanClock_ff <= testReset && pinIn[TCK_PIN]; // R1 R2
			scanDataIn_ff <= testReset && pinIn[TDI_PIN]; // R1
			scanModeSel_ff <= testReset && pinIn[TMS_PIN]; // R1
		end
	end

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rresp = rresp_ff;
	assign rdata = rdata_ff;
	assign pinOut = pinOut_ff;
	assign pinOe = pinOe_ff;
	assign periphIn = periphIn_ff;
	assign scanClock = scanClock_ff;
	assign scanDataIn = scanDataIn_ff;
	assign scanModeSel = scanModeSel_ff;
endmodule : pin_function_mux_qualifier

// File: testbench/pin_mux_checker.sv
`timescale 1ns/100ps
module pin_mux_checker #(
	parameter int PINS = 32,
	parameter int TCK_PIN = 28,
	parameter int TDI_PIN = 29,
	parameter int TMS_PIN = 30,
	parameter int TDO_PIN = 31
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic testReset,
	input wire logic scanDataOutOe,
	input wire logic [PINS-1:0] pinIn,
	input wire logic [PINS-1:0] pinOe,
	input wire logic scanClock,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid
);
	logic [1:0] age_ff;
	logic live;
	// outputs stay clear until the internal reset copy lets go
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) age_ff <= 2'h0;
		else if (!live) age_ff <= age_ff + 2'h1;
	end
	assign live = age_ff == 2'h3;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	scan_clock_a: assert property (live && $past(testReset) |-> scanClock == $past(pinIn[TCK_PIN]))
		else $error("scan clock wrong");
	scan_idle_a: assert property (live && !$past(testReset) |-> !scanClock)
		else $error("scan clock not idle");
	scan_own_a: assert property (live && $past(testReset) |-> {pinOe[TCK_PIN], pinOe[TDI_PIN], pinOe[TMS_PIN]} == 3'h0)
		else $error("scan pin still driven");
	tdo_drive_a: assert property (live && $past(testReset) |-> pinOe[TDO_PIN] == $past(scanDataOutOe))
		else $error("scan data out enable wrong");
	write_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write response late");
	read_resp_a: assert property (arvalid && arready |=> rvalid)
		else $error("read response late");
	read_busy_a: assert property (rvalid |-> !arready)
		else $error("read taken while busy");
	bad_read_a: assert property (arvalid && arready && araddr[7:2] > 6'h6 |=> rresp == 2'h2 && rdata == 32'h0)
		else $error("unmapped read answered");
endmodule : pin_mux_checker
bind pin_function_mux_qualifier pin_mux_checker #(.PINS(PINS), .TCK_PIN(TCK_PIN), .TDI_PIN(TDI_PIN),
	.TMS_PIN(TMS_PIN), .TDO_PIN(TDO_PIN)) chk_u (.clk(clk), .rst_n(rst_n), .testReset(testReset),
	.scanDataOutOe(scanDataOutOe), .pinIn(pinIn), .pinOe(pinOe), .scanClock(scanClock), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid));

// File: testbench/pin_board.sv
`timescale 1ns/100ps
module pin_board (
	input wire logic [31:0] pinOut,
	input wire logic [31:0] pinOe,
	input wire logic [31:0] ext,
	input wire logic [95:0] pat,
	output logic [31:0] pinIn,
	output logic [95:0] periphOut,
	output logic [95:0] periphOe
);
	// an undriven pin sees the board level
	assign pinIn = (pinOe & pinOut) | (~pinOe & ext);
	assign periphOut = pat;
	assign periphOe = {pat[94:0], pat[95]};
endmodule : pin_board

// File: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
	import pin_mux_pkg::*;
	logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, pinIn, pinOut, pinOe, ext;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [95:0] periphOut, periphOe, pat;
	logic [15:0] periphIn;
	logic testReset, scanDataOut, scanDataOutOe, scanClock, scanDataIn, scanModeSel;
	int error_cnt, n_compared;
	pin_function_mux_qualifier #(.PERIN_DEFAULT(16'hA5CB)) dut_u (.*);
	pin_board board_u (.pinOut(pinOut), .pinOe(pinOe), .ext(ext), .pat(pat), .pinIn(pinIn),
		.periphOut(periphOut), .periphOe(periphOe));
	always #5 clk = ~clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		logic [1:0] r;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		forever begin
			@(negedge clk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			r = bresp;
			@(posedge clk);
			if (aw) awvalid <= 1'h0;
			if (w) wvalid <= 1'h0;
			if (b) break;
		end
		bready <= 1'h0;
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ar, rv;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		forever begin
			@(negedge clk);
			ar = arvalid && arready;
			rv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ar) arvalid <= 1'h0;
			if (rv) break;
		end
		rready <= 1'h0;
		chk("rdata", e, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask : rd
	task automatic t_reset;
		logic [7:0] ofs[7] = '{OFS_QUAL_CTRL, OFS_QSEL_LOW, OFS_QSEL_HIGH, OFS_FSEL_LOW, OFS_FSEL_HIGH,
			OFS_DIRECTION, OFS_PIN_DATA};
		@(negedge clk);
		chk("periphIn", 32'h0000A5CB, {16'h0, periphIn});
		chk("pinOe", 32'h0, pinOe);
		for (int i = 0; i < 7; i++) begin
			rd(ofs[i], RST_REG, RESP_OKAY);
		end
		rd(8'h1C, 32'h0, RESP_SLVERR);
		wr(8'h1C, 32'h1, RESP_SLVERR);
		// only byte lane 1 may land
		wstrb <= 4'h2;
		wr(OFS_DIRECTION, 32'hFFFFFFFF, RESP_OKAY);
		wstrb <= 4'hF;
		rd(OFS_DIRECTION, 32'h0000FF00, RESP_OKAY);
		$display("reset test done");
	endtask : t_reset
	task automatic t_gpio;
		wr(OFS_DIRECTION, 32'hFFFFFFFF, RESP_OKAY);
		wr(OFS_PIN_DATA, 32'hA5A55A5A, RESP_OKAY);
		repeat (2) @(negedge clk);
		chk("pinOe", 32'hFFFFFFFF, pinOe);
		chk("pinOut", 32'hA5A55A5A, pinOut);
		repeat (3) @(negedge clk);
		rd(OFS_PIN_DATA, 32'hA5A55A5A, RESP_OKAY);
		$display("gpio test done");
	endtask : t_gpio
	task automatic t_fsel;
		logic [31:0] eo;
		logic [31:0] ee;
		eo = 32'hA5A55A5A;
		pat <= {32{3'h1}};
		for (int s = 1; s < 4; s++) begin
			wr(OFS_FSEL_LOW, {16{s[1:0]}}, RESP_OKAY);
			repeat (2) @(negedge clk);
			chk("pinOut held", eo, pinOut);
			@(negedge clk);
			eo = {16'hA5A5, (s == 1) ? 16'hFFFF : 16'h0};
			ee = {16'hFFFF, (s == 2) ? 16'hFFFF : 16'h0};
			chk("pinOut", eo, pinOut);
			chk("pinOe", ee, pinOe);
		end
		wr(OFS_FSEL_LOW, 32'h0, RESP_OKAY);
		wr(OFS_DIRECTION, 32'h0, RESP_OKAY);
		pat <= 96'h0;
		$display("function select test done");
	endtask : t_fsel
	task automatic t_qual;
		wr(OFS_QUAL_CTRL, 32'h00000002, RESP_OKAY);
		wr(OFS_QSEL_LOW, 32'hAAAAAAAA, RESP_OKAY);
		wr(OFS_QSEL_HIGH, 32'hFFFF5555, RESP_OKAY);
		repeat (4) @(posedge clk);
		ext <= 32'hFFFFFFFF;
		repeat (10) @(posedge clk);
		rd(OFS_PIN_DATA, 32'hFFFFFF00, RESP_OKAY);
		repeat (40) @(posedge clk);
		rd(OFS_PIN_DATA, 32'hFFFFFFFF, RESP_OKAY);
		ext <= 32'h0;
		repeat (2) @(posedge clk);
		ext <= 32'hFFFFFFFF;
		// read while the two-cycle dip is still inside the six-sample window of pins 8-15
		repeat (6) @(posedge clk);
		rd(OFS_PIN_DATA, 32'hFFFFFFFF, RESP_OKAY);
		$display("qualifier test done");
	endtask : t_qual
	task automatic t_periph;
		logic [31:0] fs[5] = '{32'h2000, 32'h4, 32'h0, 32'h4, 32'h0};
		logic [7:0] fa[5] = '{OFS_FSEL_LOW, OFS_FSEL_LOW, OFS_FSEL_LOW, OFS_FSEL_HIGH, OFS_FSEL_HIGH};
		logic [15:0] ex[5] = '{16'hA5C3, 16'hA5C3, 16'hA5CB, 16'hA5C3, 16'hA5CB};
		ext <= 32'hFFBDFFBD;
		wr(OFS_QSEL_LOW, 32'h0, RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			wr(fa[i], fs[i], RESP_OKAY);
			repeat (6) @(negedge clk);
			chk("periphIn", {16'h0, ex[i]}, {16'h0, periphIn});
		end
		$display("peripheral input test done");
	endtask : t_periph
	task automatic t_scan;
		wr(OFS_DIRECTION, 32'hFFFFFFFF, RESP_OKAY);
		wr(OFS_PIN_DATA, 32'h0, RESP_OKAY);
		ext <= 32'hFFFFFFFF;
		testReset <= 1'h1;
		scanDataOut <= 1'h1;
		scanDataOutOe <= 1'h1;
		repeat (4) @(negedge clk);
		chk("pinOe", 32'h8FFFFFFF, pinOe);
		chk("pinOut", 32'h80000000, pinOut);
		chk("scan", 32'h7, {29'h0, scanClock, scanDataIn, scanModeSel});
		@(posedge clk);
		testReset <= 1'h0;
		repeat (4) @(negedge clk);
		chk("pinOe", 32'hFFFFFFFF, pinOe);
		chk("scan", 32'h0, {29'h0, scanClock, scanDataIn, scanModeSel});
		$display("scan port test done");
	endtask : t_scan
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out
	initial begin
		clk = 1'h0;
		rst_n = 1'h0;
		{awvalid, wvalid, bready, arvalid, rready, testReset, scanDataOut, scanDataOutOe} = 8'h0;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		ext = 32'h0;
		pat = 96'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		t_reset();
		t_gpio();
		t_fsel();
		t_qual();
		t_periph();
		t_scan();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		close_out();
	end
endmodule : testbench
